// *** src/sfs_supervisor.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sfs_consts.vh"

module sfs_supervisor (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Analogue comparators, asynchronous, high when the supply is above threshold
  input wire logic_supply_rise_threshold,
  input wire logic_supply_fall_threshold,
  input wire pump_supply_rise_threshold,
  input wire pump_supply_fall_threshold,
  // Parallel-mode pins, asynchronous
  input wire pump_enable_pin,
  input wire fault_shutdown_select_pin,
  input wire [3:0] switch_state_pins,
  // Open-drain fault pin, active low
  output reg fault_out_n_o,
  output reg fault_out_n_oe,
  // Driver outputs
  output reg [3:0] hv_out,
  output reg pump_on,
  output reg sleep_out,
  // Interrupt
  output reg irq
);

  // Synchronised comparator and pin inputs.
  wire lrise_s;
  wire lfall_s;
  wire prise_s;
  wire pfall_s;
  wire pen_pin_s;
  wire shdn_pin_s;
  wire [3:0] sw_pin_s;

  sfs_sync2 u_sync_lrise (.mclk(mclk), .rst_n(rst_n), .async_in(logic_supply_rise_threshold),
    .sync_out(lrise_s));
  sfs_sync2 u_sync_lfall (.mclk(mclk), .rst_n(rst_n), .async_in(logic_supply_fall_threshold),
    .sync_out(lfall_s));
  sfs_sync2 u_sync_prise (.mclk(mclk), .rst_n(rst_n), .async_in(pump_supply_rise_threshold),
    .sync_out(prise_s));
  sfs_sync2 u_sync_pfall (.mclk(mclk), .rst_n(rst_n), .async_in(pump_supply_fall_threshold),
    .sync_out(pfall_s));
  sfs_sync2 u_sync_pen (.mclk(mclk), .rst_n(rst_n), .async_in(pump_enable_pin),
    .sync_out(pen_pin_s));
  sfs_sync2 u_sync_shdn (.mclk(mclk), .rst_n(rst_n), .async_in(fault_shutdown_select_pin),
    .sync_out(shdn_pin_s));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sw
      sfs_sync2 u_sync_sw (.mclk(mclk), .rst_n(rst_n), .async_in(switch_state_pins[gi]),
        .sync_out(sw_pin_s[gi]));
    end
  endgenerate

  // Bus handshake.
  wire wr_stb;
  wire rd_stb;
  wire ack;

  sfs_wb_slave u_wb (
    .mclk(mclk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .ack(ack)
  );

  // Registers.
  reg [7:0] state_ff;
  reg [7:0] control_ff;
  reg mode_ff;
  reg armed_ff;
  reg shdn_ff;
  reg pen_prev_ff;
  reg restart_low_ff;
  reg fault_prev_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;

  // Mode: 0 is serial (register) control, 1 is parallel (pin) control.
  wire serial_mode = ~mode_ff;
  wire pump_en_eff = serial_mode ? control_ff[`SFS_CTL_PUMP_EN] : pen_pin_s;
  wire shdn_sel_eff = serial_mode ? control_ff[`SFS_CTL_SHDN_SEL] : shdn_pin_s;

  // Pump under-voltage is watched only while the comparator is enabled in serial mode, or while the pump enable pin is high in parallel mode.
  wire pump_watch = serial_mode ? ~control_ff[`SFS_CTL_UV_DIS]
                                : pen_pin_s;

  // Both fault sources are evaluated independently.
  wire logic_uv = ~lfall_s;
  wire pump_uv = pump_watch & ~pfall_s;
  // The combined fault stays while either watched supply is still below trip.
  wire combined_fault = armed_ff & (logic_uv | pump_uv);

  // Arming waits for the logic rise threshold, and for the pump one while it is watched, so power-up ramps cannot flag a fault.
  wire arm_ok = lrise_s & (prise_s | ~pump_watch);

  // Byte-lane write helper.
  wire wr_lane0 = wr_stb & wb_sel_i[0];

  function [7:0] rd_mux;
    input [7:0] adr;
    input [7:0] st;
    input [7:0] ct;
    input [4:0] sts;
    input [2:0] ist;
    input [2:0] imk;
    input md;
    begin
      case (adr)
        `SFS_ADDR_STATE: rd_mux = st;
        `SFS_ADDR_CONTROL: rd_mux = ct;
        `SFS_ADDR_STATUS: rd_mux = {3'h0, sts};
        `SFS_ADDR_IRQ_STAT: rd_mux = {5'h00, ist};
        `SFS_ADDR_IRQ_MASK: rd_mux = {5'h00, imk};
        `SFS_ADDR_MODE: rd_mux = {7'h00, md};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  wire [4:0] status_vec = {shdn_ff, armed_ff, combined_fault, pump_uv, logic_uv};

  wire fault_rise = combined_fault & ~fault_prev_ff;
  wire fault_fall = ~combined_fault & fault_prev_ff;
  wire shdn_event = fault_rise & ~shdn_sel_eff;

  // Restart needs the enable to be seen low and then high after the trip.
  wire restart = shdn_ff & restart_low_ff & pump_en_eff;

  reg nxt_fault_status_latched;
  reg [7:0] nxt_control;

  always @* begin
    nxt_control = control_ff;
    if (wr_lane0 && wb_adr_i == `SFS_ADDR_CONTROL) begin
      nxt_control = wb_dat_i[7:0];
      // Status bit is not loadable to one by software; only a zero write clears it.
      nxt_control[`SFS_CTL_FAULT_STATUS_LATCHED] = control_ff[`SFS_CTL_FAULT_STATUS_LATCHED] & wb_dat_i[`SFS_CTL_FAULT_STATUS_LATCHED];
    end
    nxt_fault_status_latched = nxt_control[`SFS_CTL_FAULT_STATUS_LATCHED] | combined_fault;
    nxt_control[`SFS_CTL_FAULT_STATUS_LATCHED] = nxt_fault_status_latched;
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= `SFS_STATE_RST;
      control_ff <= `SFS_CONTROL_RST;
      mode_ff <= `SFS_MODE_RST;
      armed_ff <= 1'b0;
      shdn_ff <= 1'b0;
      pen_prev_ff <= 1'b0;
      restart_low_ff <= 1'b0;
      fault_prev_ff <= 1'b0;
      irq_stat_ff <= `SFS_MASK_RST;
      irq_mask_ff <= `SFS_MASK_RST;
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'b0;
      fault_out_n_o <= 1'b0;
      fault_out_n_oe <= 1'b0;
      hv_out <= 4'h0;
      pump_on <= 1'b0;
      sleep_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      control_ff <= nxt_control;
      if (wr_lane0 && wb_adr_i == `SFS_ADDR_STATE) begin
        state_ff <= {4'h0, wb_dat_i[3:0]};
      end
      if (wr_lane0 && wb_adr_i == `SFS_ADDR_MODE) begin
        mode_ff <= wb_dat_i[0];
      end
      if (wr_lane0 && wb_adr_i == `SFS_ADDR_IRQ_MASK) begin
        irq_mask_ff <= wb_dat_i[2:0];
      end
      // A new event wins over a write-one clear in the same cycle.
      if (wr_lane0 && wb_adr_i == `SFS_ADDR_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[2:0]) | {shdn_event, fault_fall, fault_rise};
      end else begin
        irq_stat_ff <= irq_stat_ff | {shdn_event, fault_fall, fault_rise};
      end
      if (arm_ok) begin
        armed_ff <= 1'b1;
      end
      fault_prev_ff <= combined_fault;
      pen_prev_ff <= pump_en_eff;
      if (fault_rise && !shdn_sel_eff) begin
        shdn_ff <= 1'b1;
        restart_low_ff <= 1'b0;
      end else if (restart && !combined_fault) begin
        shdn_ff <= 1'b0;
        restart_low_ff <= 1'b0;
      end else if (shdn_ff && !pump_en_eff) begin
        restart_low_ff <= 1'b1;
      end
      wb_ack_o <= ack;
      if (rd_stb) begin
        wb_dat_o <= {24'h000000, rd_mux(wb_adr_i, state_ff, control_ff, status_vec,
          irq_stat_ff, irq_mask_ff, mode_ff)};
      end
      // Pin is released before arming and whenever no fault is present.
      fault_out_n_o <= 1'b0;
      fault_out_n_oe <= combined_fault;
      // Shutdown blocks both outputs; with shutdown disabled nothing changes.
      if (shdn_ff || (fault_rise && !shdn_sel_eff)) begin
        hv_out <= 4'h0;
        pump_on <= 1'b0;
      end else begin
        hv_out <= serial_mode ? state_ff[3:0] : sw_pin_s;
        pump_on <= pump_en_eff;
      end
      sleep_out <= serial_mode & control_ff[`SFS_CTL_SLEEP];
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

endmodule // sfs_supervisor

`default_nettype wire

// *** src/sfs_consts.vh ***
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH

// Wishbone register word addresses (byte offsets, 32-bit words).
`define SFS_ADDR_STATE 8'h00
`define SFS_ADDR_CONTROL 8'h04
`define SFS_ADDR_STATUS 8'h08
`define SFS_ADDR_IRQ_STAT 8'h0C
`define SFS_ADDR_IRQ_MASK 8'h10
`define SFS_ADDR_MODE 8'h14

// Control register fields.
`define SFS_CTL_PUMP_EN 1
`define SFS_CTL_UV_DIS 3
`define SFS_CTL_SHDN_SEL 4
`define SFS_CTL_SLEEP 5
`define SFS_CTL_FAULT_STATUS_LATCHED 6
`define SFS_CTL_WR_EN 7

// Status register fields.
`define SFS_ST_LOGIC_UV 0
`define SFS_ST_PUMP_UV 1
`define SFS_ST_FAULT 2
`define SFS_ST_ARMED 3
`define SFS_ST_SHDN 4

// Interrupt event bits.
`define SFS_IRQ_FAULT_SET 0
`define SFS_IRQ_FAULT_CLR 1
`define SFS_IRQ_SHDN 2
`define SFS_IRQ_W 3

// Reset values.
`define SFS_STATE_RST 8'h00
`define SFS_CONTROL_RST 8'h00
`define SFS_MASK_RST 3'h0
`define SFS_MODE_RST 1'h0

`endif

// *** src/sfs_sync2.v ***
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a single asynchronous level.
module sfs_sync2 (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Data
  input wire async_in,
  output wire sync_out
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // sfs_sync2

`default_nettype wire

// *** src/sfs_wb_slave.v ***
`timescale 1ns/1ps
`default_nettype none

// Classic Wishbone slave handshake: the request is taken on one edge and acked on the next.
module sfs_wb_slave (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Bus request
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  // Access strobes toward the register file
  output wire wr_stb,
  output wire rd_stb,
  output wire ack
);

  reg ack_ff;
  wire take;

  // The ack flop mirrors the registered bus ack, so a held request is never taken on two edges in a row.
  assign take = wb_cyc_i & wb_stb_i & ~ack_ff;

  always @(posedge mclk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // Writes land on the edge where the master samples ack; read data is loaded one edge earlier.
  assign wr_stb = ack_ff & wb_cyc_i & wb_stb_i & wb_we_i;
  assign rd_stb = take & ~wb_we_i;
  assign ack = take;

endmodule // sfs_wb_slave

`default_nettype wire

// *** testbench/sfs_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfs_props (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Supplies and outputs
  input wire logic_supply_fall_threshold,
  input wire pump_supply_fall_threshold,
  input wire fault_out_n_o,
  input wire fault_out_n_oe,
  input wire [3:0] hv_out,
  input wire pump_on,
  input wire irq
);
  wire any_low = !(logic_supply_fall_threshold && pump_supply_fall_threshold);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence req_s;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence boot_s;
    $rose(rst_n);
  endsequence
  od_drive_a: assert property (fault_out_n_o == 1'b0)
    else $error("fault pin driven high");
  ack_time_a: assert property (req_s |-> ##[1:3] wb_ack_o)
    else $error("bus answer late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer too long");
  rdata_hi_a: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  reset_clear_a: assert property (boot_s |-> hv_out == 4'h0 && !pump_on && !irq)
    else $error("outputs not cleared by reset");
  arm_gate_a: assert property (boot_s |-> !fault_out_n_oe [*3])
    else $error("fault pin driven before arming");
  // Sync depth plus output register puts the cause three to five edges back.
  pin_cause_a: assert property (fault_out_n_oe |->
    $past(any_low, 3) || $past(any_low, 4) || $past(any_low, 5))
    else $error("fault pin without a supply drop");
  pin_release_a: assert property (!any_low [*6] |-> !fault_out_n_oe)
    else $error("fault pin held with supplies good");
endmodule // sfs_props

bind sfs_supervisor sfs_props u_props (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .logic_supply_fall_threshold, .pump_supply_fall_threshold, .fault_out_n_o,
  .fault_out_n_oe, .hv_out, .pump_on, .irq);

`default_nettype wire

// *** testbench/sfs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfs_host_model (
  // Supply levels set by the bench
  input wire logic lg_ok,
  input wire logic pp_ok,
  // Comparators
  output logic logic_supply_rise_threshold,
  output logic logic_supply_fall_threshold,
  output logic pump_supply_rise_threshold,
  output logic pump_supply_fall_threshold,
  // Open-drain fault pin
  input wire logic fault_out_n_o,
  input wire logic fault_out_n_oe,
  output logic fault_pin
);
  // Hysteresis is not modelled, so both trips of a supply move together.
  assign {logic_supply_rise_threshold, logic_supply_fall_threshold} = {2{lg_ok}};
  assign {pump_supply_rise_threshold, pump_supply_fall_threshold} = {2{pp_ok}};
  // The board pull-up lifts the pin whenever the device lets go of it.
  assign fault_pin = fault_out_n_oe ? fault_out_n_o : 1'b1;
endmodule // sfs_host_model

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sfs_consts.vh"

module tb;
  logic mclk, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lg_ok = 0, pp_ok = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF, switch_state_pins = 0, sw = 0;
  logic [31:0] wb_dat_i = 0, rd;
  logic pump_enable_pin = 0, fault_shutdown_select_pin = 1, md = 0, arm = 0, fst = 0;
  logic [7:0] ctl = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, fault_out_n_o, fault_out_n_oe, pump_on, sleep_out, irq, fault_pin;
  wire logic_supply_rise_threshold, logic_supply_fall_threshold;
  wire pump_supply_rise_threshold, pump_supply_fall_threshold;
  wire pmon = md ? pump_enable_pin : !ctl[3];
  wire eo = arm && (!lg_ok || (pmon && !pp_ok));
  wire [3:0] hv_out;
  integer num_errors = 0, tests_run = 0, cyc_n = 0;
  sfs_supervisor uut (.*);
  sfs_host_model u_host (.*);
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // A clearing write loses to a fault that is still live.
  task wc(input logic [7:0] d);
    wb(1, `SFS_ADDR_CONTROL, d);
    ctl = d;
    if (!d[6]) fst = eo;
  endtask
  task step;
    repeat (6) @(posedge mclk);
    fst = fst | eo;
    chk(fault_pin, !eo);
    wb(0, `SFS_ADDR_CONTROL, 8'h00);
    if (!md) chk(rd[6], fst);
  endtask
  initial begin
    void'($urandom(46));
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    wb(0, `SFS_ADDR_CONTROL, 8'h00);
    chk(rd, 32'h0);
    wb(0, `SFS_ADDR_STATE, 8'h00);
    chk(rd, 32'h0);
    wb(0, 8'h3C, 8'h00);
    chk(rd, 32'h0);
    step;
    {lg_ok, pp_ok} <= 2'b11;
    repeat (6) @(posedge mclk);
    arm = 1;
    wc(8'h82);
    sw = $urandom;
    switch_state_pins <= $urandom;
    wb(1, `SFS_ADDR_STATE, {4'h0, sw});
    step;
    chk(hv_out, sw);
    lg_ok <= 0;
    step;
    chk(hv_out, 4'h0);
    chk(pump_on, 1'b0);
    chk(irq, 1'b0);
    wb(1, `SFS_ADDR_IRQ_MASK, 8'h01);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    lg_ok <= 1;
    step;
    wb(1, `SFS_ADDR_IRQ_STAT, 8'h07);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    wc(8'hC2);
    step;
    wc(8'h82);
    step;
    chk(pump_on, 1'b0);
    wc(8'hA2);
    repeat (3) @(posedge mclk);
    chk(sleep_out, 1'b1);
    chk(pump_on, 1'b0);
    wc(8'h80);
    wc(8'h82);
    repeat (4) @(posedge mclk);
    chk(pump_on, 1'b1);
    wc(8'h8A);
    pp_ok <= 0;
    step;
    wc(8'h82);
    step;
    {lg_ok, pp_ok} <= 2'b01;
    step;
    lg_ok <= 1;
    step;
    wc(8'h80);
    wc(8'h92);
    lg_ok <= 0;
    step;
    chk(pump_on, 1'b1);
    chk(hv_out, sw);
    lg_ok <= 1;
    step;
    wb(1, `SFS_ADDR_MODE, 8'h01);
    md = 1;
    pp_ok <= 0;
    step;
    pump_enable_pin <= 1;
    step;
    pp_ok <= 1;
    step;
    conclude;
  end
endmodule // tb

`default_nettype wire
